// File: shared/srq_pkg.sv
// constants shared by both ends of the session request link
// assumes a single 200 MHz clock and an 8-bit register port
package srq_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] SRQ_ADDR_CTRL   = 8'h12;
  localparam int         SRQ_BIT_EN      = 0;
  localparam int         SRQ_BIT_VPULSE  = 1;
  localparam int         SRQ_BIT_DISCH   = 2;
  localparam int         SRQ_BIT_INITV   = 3;
  localparam int         SRQ_BIT_SVALID  = 4;
  localparam int         SRQ_BIT_LPULSE  = 5;
  localparam logic [7:0] SRQ_CTRL_RESET  = 8'h00;
  localparam logic [7:0] SRQ_RD_UNMAPPED = 8'h00;

  // ==========================================================
  // timing, figures in ms, cycle counts derived
  localparam int SRQ_CLK_HZ        = 200_000_000;
  localparam int SRQ_MS_CYCLES     = SRQ_CLK_HZ / 1000;
  localparam int SRQ_INIT_WAIT_MS  = 3;    // must exceed 2 ms
  localparam int SRQ_LINE_MS       = 7;    // 5 to 10 ms
  localparam int SRQ_VBUS_MS       = 18;   // 16 to 20 ms
  localparam int SRQ_DISCH_MS      = 30;   // about 30 ms
  localparam int SRQ_RESP_MS       = 5000; // host answer limit
  localparam int SRQ_MS_W          = 13;

endpackage

// File: shared/srq_if.sv
// register port between controller logic and its firmware end
// assumes both ends share ref_clk; testbench instantiates it
`timescale 1ns/1ps
`default_nettype none
interface srq_if;
  // ==========================================================
  // register port signals
  logic [7:0] reg_addr;   // register address
  logic [7:0] reg_wdata;  // write data
  logic       reg_wr;     // one-cycle write strobe
  logic       reg_rd;     // one-cycle read strobe
  logic [7:0] reg_rdata;  // read data, valid with reg_rvalid
  logic       reg_rvalid; // one-cycle read answer

  // controller end answers reads
  modport dev (
    input  reg_addr, reg_wdata, reg_wr, reg_rd,
    output reg_rdata, reg_rvalid
  );
  // firmware end issues accesses
  modport fw (
    output reg_addr, reg_wdata, reg_wr, reg_rd,
    input  reg_rdata, reg_rvalid
  );
endinterface
`default_nettype wire

// File: rtl/srq_device.sv
// controller end: session request control register and drives
// assumes cable sense inputs are already synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module srq_device
  import srq_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // register port
  srq_if.dev        bus,
  // cable sense
  input  wire logic vbus_below_0v8,  // bus power under 0.8 V
  input  wire logic line_se0,        // both data lines low
  input  wire logic vbus_sess_valid, // above session threshold
  // cable drives
  output logic      line_pulse_drv,  // pull positive line up
  output logic      vbus_pulse_drv,  // pulse bus power
  output logic      vbus_disch_drv,  // discharge bus power
  output logic      vbus_sense_en    // normal power sensing on
);

  // ==========================================================
  // storage
  logic session_en;            // function enable
  logic bus_power_pulse;       // control bit
  logic bus_power_discharge;   // control bit
  logic line_pulse;            // control bit
  logic srp_initial_violation; // sticky status
  logic peripheral_session_valid; // sticky status

  // ==========================================================
  // decode
  wire sel      = bus.reg_addr == SRQ_ADDR_CTRL;
  wire wr_ctrl  = bus.reg_wr && sel;
  wire init_bad = session_en && !(vbus_below_0v8 && line_se0);
  wire [7:0] ctrl_view = {2'b00, line_pulse,
    peripheral_session_valid, srp_initial_violation,
    bus_power_discharge, bus_power_pulse, session_en};

  // sticky flag: set wins over a write-one clear
  function automatic logic sticky(input logic cur,
      input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // ==========================================================
  // control bits, plain read/write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      session_en          <= 1'b0;
      bus_power_pulse     <= 1'b0;
      bus_power_discharge <= 1'b0;
      line_pulse          <= 1'b0;
    end else if (wr_ctrl) begin
      session_en          <= bus.reg_wdata[SRQ_BIT_EN];
      bus_power_pulse     <= bus.reg_wdata[SRQ_BIT_VPULSE];
      bus_power_discharge <= bus.reg_wdata[SRQ_BIT_DISCH];
      line_pulse          <= bus.reg_wdata[SRQ_BIT_LPULSE];
    end
  end

  // status flags; zero writes leave them alone
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      srp_initial_violation    <= 1'b0;
      peripheral_session_valid <= 1'b0;
    end else begin
      srp_initial_violation <= sticky(srp_initial_violation,
        init_bad,
        wr_ctrl & bus.reg_wdata[SRQ_BIT_INITV]);
      // valid keeps tracking with the enable low, since firmware
      // polls it only after disabling the function
      peripheral_session_valid <= sticky(
        peripheral_session_valid, vbus_sess_valid,
        wr_ctrl & bus.reg_wdata[SRQ_BIT_SVALID]);
    end
  end

  // ==========================================================
  // read answer one cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus.reg_rvalid <= 1'b0;
      bus.reg_rdata  <= SRQ_RD_UNMAPPED;
    end else begin
      bus.reg_rvalid <= bus.reg_rd;
      bus.reg_rdata  <= (bus.reg_rd && sel) ? ctrl_view
                                            : SRQ_RD_UNMAPPED;
    end
  end

  // ==========================================================
  // cable drives, gated by the enable, sensing on while it is low; no interrupt of its own,
  // so the sensing path is the only thing that may flag events
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      line_pulse_drv <= 1'b0;
      vbus_pulse_drv <= 1'b0;
      vbus_disch_drv <= 1'b0;
      vbus_sense_en  <= 1'b1;
    end else begin
      line_pulse_drv <= session_en & line_pulse;
      vbus_pulse_drv <= session_en & bus_power_pulse;
      vbus_disch_drv <= session_en & bus_power_discharge;
      vbus_sense_en  <= ~session_en;
    end
  end

endmodule
`default_nettype wire

// File: rtl/srq_firmware.sv
// firmware end: runs one session request on a start pulse
// assumes the controller end answers a read one cycle later;
// ms_cycles sets the millisecond tick and may be shortened
`timescale 1ns/1ps
`default_nettype none
module srq_firmware
  import srq_pkg::*;
#(
  parameter int MS_CYCLES = SRQ_MS_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // register port
  srq_if.fw         bus,
  // user side
  input  wire logic start,        // one-cycle request
  input  wire logic use_discharge,// add the discharge step
  output logic      busy,         // sequence running
  output logic      done,         // one-cycle end pulse
  output logic      success,      // last result good
  output logic      fail_init,    // conditions violated
  output logic      fail_timeout, // no answer within 5 s
  output logic      soft_attach   // pull-up for enumeration
);

  // ==========================================================
  // sequence states
  typedef enum logic [4:0] {
    S_IDLE, S_EN, S_CLR_INIT, S_WAIT_INIT, S_RD_INIT, S_CK_INIT,
    S_LINE_ON, S_LINE_WAIT, S_LINE_OFF, S_VBUS_ON, S_VBUS_WAIT,
    S_VBUS_OFF, S_DIS_ON, S_DIS_WAIT, S_DIS_OFF, S_DISABLE,
    S_POLL_RD, S_POLL_CK, S_ABORT, S_FINISH
  } srq_state_t;

  srq_state_t         state;      // current step
  srq_state_t         next_state; // following step
  logic [17:0]        tick_cnt;   // cycles within one ms
  logic               ms_tick;    // one-cycle ms enable
  logic [SRQ_MS_W-1:0] ms_cnt;    // ms spent in a wait state
  logic               ms_clr;     // restart the ms count
  logic               good;       // result to latch
  logic               bad_init;   // abort cause

  // control byte builder for writes
  function automatic logic [7:0] ctl(input logic en,
      input logic lp, input logic vp, input logic dc,
      input logic clr_iv);
    ctl = 8'h00;
    ctl[SRQ_BIT_EN]     = en;
    ctl[SRQ_BIT_LPULSE] = lp;
    ctl[SRQ_BIT_VPULSE] = vp;
    ctl[SRQ_BIT_DISCH]  = dc;
    ctl[SRQ_BIT_INITV]  = clr_iv;
  endfunction

  // ==========================================================
  // millisecond enable divider
  wire tick_end = tick_cnt == 18'(MS_CYCLES - 1);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 18'h0_0000;
      ms_tick  <= 1'b0;
    end else begin
      tick_cnt <= tick_end ? 18'h0_0000 : tick_cnt + 18'h0_0001;
      ms_tick  <= tick_end;
    end
  end

  // ms counter for each wait; first ms may be short by under
  // one tick, so only the init wait figure keeps a margin of one ms
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ms_cnt <= '0;
    end else if (ms_clr) begin
      ms_cnt <= '0;
    end else if (ms_tick) begin
      ms_cnt <= ms_cnt + SRQ_MS_W'(1);
    end
  end

  wire init_done = ms_cnt == SRQ_MS_W'(SRQ_INIT_WAIT_MS + 1);
  wire line_done = ms_cnt == SRQ_MS_W'(SRQ_LINE_MS);
  wire vbus_done = ms_cnt == SRQ_MS_W'(SRQ_VBUS_MS);
  wire dis_done  = ms_cnt == SRQ_MS_W'(SRQ_DISCH_MS);
  wire resp_done = ms_cnt == SRQ_MS_W'(SRQ_RESP_MS);
  wire rd_iv     = bus.reg_rdata[SRQ_BIT_INITV];
  wire rd_sv     = bus.reg_rdata[SRQ_BIT_SVALID];

  // ==========================================================
  // step selection
  always_comb begin
    next_state = state;
    ms_clr     = 1'b1;
    case (state)
      S_IDLE:      if (start) next_state = S_EN;
      S_EN:        next_state = S_CLR_INIT;
      S_CLR_INIT:  next_state = S_WAIT_INIT;
      S_WAIT_INIT: begin
        ms_clr = 1'b0;
        if (init_done) next_state = S_RD_INIT;
      end
      S_RD_INIT:   next_state = S_CK_INIT;
      S_CK_INIT:   if (bus.reg_rvalid) begin
        next_state = rd_iv ? S_ABORT : S_LINE_ON;
      end
      S_LINE_ON:   next_state = S_LINE_WAIT;
      S_LINE_WAIT: begin
        ms_clr = 1'b0;
        if (line_done) next_state = S_LINE_OFF;
      end
      S_LINE_OFF:  next_state = S_VBUS_ON;
      S_VBUS_ON:   next_state = S_VBUS_WAIT;
      S_VBUS_WAIT: begin
        ms_clr = 1'b0;
        if (vbus_done) next_state = S_VBUS_OFF;
      end
      S_VBUS_OFF:  begin
        // both pulses are over here, 25 ms in, under 100 ms
        next_state = use_discharge ? S_DIS_ON : S_DISABLE;
      end
      S_DIS_ON:    next_state = S_DIS_WAIT;
      S_DIS_WAIT:  begin
        ms_clr = 1'b0;
        if (dis_done) next_state = S_DIS_OFF;
      end
      S_DIS_OFF:   next_state = S_DISABLE;
      S_DISABLE:   next_state = S_POLL_RD;
      S_POLL_RD:   begin
        ms_clr     = 1'b0;
        next_state = S_POLL_CK;
      end
      S_POLL_CK:   begin
        ms_clr = 1'b0;
        if (bus.reg_rvalid) begin
          if (rd_sv) begin
            next_state = S_FINISH;
          end else if (resp_done) begin
            next_state = S_FINISH;
          end else begin
            next_state = S_POLL_RD;
          end
        end
      end
      S_ABORT:     next_state = S_FINISH;
      S_FINISH:    next_state = S_IDLE;
      default:     next_state = S_IDLE;
    endcase
  end

  // result decided on the poll answer or on the init check answer
  assign good     = state == S_POLL_CK && bus.reg_rvalid && rd_sv;
  assign bad_init = state == S_CK_INIT && bus.reg_rvalid && rd_iv;

  // ==========================================================
  // register accesses, one strobe per write or read step
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus.reg_wr    <= 1'b0;
      bus.reg_rd    <= 1'b0;
      bus.reg_addr  <= SRQ_ADDR_CTRL;
      bus.reg_wdata <= SRQ_CTRL_RESET;
    end else begin
      bus.reg_wr <= 1'b0;
      bus.reg_rd <= 1'b0;
      case (next_state)
        S_EN: begin
          bus.reg_wr    <= state != S_EN;
          bus.reg_wdata <= ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        S_CLR_INIT: begin
          bus.reg_wr    <= 1'b1;
          bus.reg_wdata <= ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        end
        S_LINE_ON: begin
          bus.reg_wr    <= 1'b1;
          bus.reg_wdata <= ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        end
        S_LINE_OFF, S_VBUS_OFF: begin
          bus.reg_wr    <= 1'b1;
          bus.reg_wdata <= ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        S_VBUS_ON: begin
          bus.reg_wr    <= 1'b1;
          bus.reg_wdata <= ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        end
        S_DIS_ON: begin
          bus.reg_wr    <= 1'b1;
          bus.reg_wdata <= ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        end
        S_DIS_OFF: begin
          // discharge cleared before any session end check
          bus.reg_wr    <= 1'b1;
          bus.reg_wdata <= ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        S_DISABLE, S_ABORT: begin
          // enable, both pulses and discharge all written low
          bus.reg_wr    <= 1'b1;
          bus.reg_wdata <= ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        S_RD_INIT, S_POLL_RD: begin
          bus.reg_rd <= 1'b1;
        end
        default: begin
          bus.reg_wr <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // state and user-side results
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state        <= S_IDLE;
      busy         <= 1'b0;
      done         <= 1'b0;
      success      <= 1'b0;
      fail_init    <= 1'b0;
      fail_timeout <= 1'b0;
      soft_attach  <= 1'b0;
    end else begin
      state <= next_state;
      busy  <= next_state != S_IDLE;
      done  <= next_state == S_FINISH;
      if (start && state == S_IDLE) begin
        success      <= 1'b0;
        fail_init    <= 1'b0;
        fail_timeout <= 1'b0;
      end
      if (good) begin
        success     <= 1'b1;
        soft_attach <= 1'b1;
      end
      if (bad_init) begin
        fail_init <= 1'b1;
      end
      if (state == S_POLL_CK && bus.reg_rvalid && !rd_sv
          && resp_done) begin
        fail_timeout <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/srq_properties.sv
// checker for the register link between the two ends
// assumes ref_clk domain only; ms_cycles matches the firmware
`timescale 1ns/1ps
`default_nettype none
module srq_properties
  import srq_pkg::*;
#(
  parameter int MS_CYCLES = SRQ_MS_CYCLES
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       nrst,
  // register link
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid
);
  // ====
  // helper state
  logic [7:0] last_w;    // last control byte written
  int         hold_cnt;  // cycles since the last write
  int         span_cnt;  // cycles since line pulse began
  logic       line_seen; // line pulse issued this request
  logic       init_pend; // violation cleared, read pending
  wire  ctl_wr = reg_wr && (reg_addr == SRQ_ADDR_CTRL);
  wire  lp_on  = ctl_wr && reg_wdata[SRQ_BIT_LPULSE];
  wire  iv_wr  = ctl_wr && reg_wdata[SRQ_BIT_INITV];
  wire  lp_off = ctl_wr && last_w[SRQ_BIT_LPULSE]
                 && !reg_wdata[SRQ_BIT_LPULSE];
  wire  vp_off = ctl_wr && last_w[SRQ_BIT_VPULSE]
                 && !reg_wdata[SRQ_BIT_VPULSE];
  // hold counter restarts per write, so hold times need no state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      last_w    <= 8'h00;
      hold_cnt  <= 0;
      span_cnt  <= 0;
      line_seen <= 1'b0;
      init_pend <= 1'b0;
    end else begin
      last_w    <= ctl_wr ? reg_wdata : last_w;
      hold_cnt  <= ctl_wr ? 0 : hold_cnt + 1;
      span_cnt  <= lp_on ? 0 : span_cnt + 1;
      line_seen <= lp_on | (line_seen & !iv_wr);
      init_pend <= iv_wr | (init_pend & !reg_rd);
    end
  end
  // ====
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_init_wait;
    reg_rd && init_pend |-> hold_cnt + 1 > 2 * MS_CYCLES;
  endproperty
  a_init_wait: assert property (p_init_wait)
    else $error("violation flag read too early");
  property p_vp_limits;
    vp_off |-> hold_cnt + 1 > 16 * MS_CYCLES
               && hold_cnt + 1 < 26 * MS_CYCLES;
  endproperty
  a_vp_limits: assert property (p_vp_limits)
    else $error("bus pulse outside its hold limits");
  property p_line_first;
    ctl_wr && reg_wdata[SRQ_BIT_VPULSE]
      |-> line_seen && !reg_wdata[SRQ_BIT_LPULSE];
  endproperty
  a_line_first: assert property (p_line_first)
    else $error("bus pulse before line pulse ended");
  property p_poll_late;
    reg_rd && !init_pend |-> line_seen && !last_w[SRQ_BIT_EN];
  endproperty
  a_poll_late: assert property (p_poll_late)
    else $error("valid poll before pulses finished");
  property p_enable_first;
    iv_wr |-> last_w[SRQ_BIT_EN] && reg_wdata[SRQ_BIT_EN];
  endproperty
  a_enable_first: assert property (p_enable_first)
    else $error("condition check before enable");
  property p_line_len;
    lp_off |-> hold_cnt + 1 >= 5 * MS_CYCLES
               && hold_cnt + 1 <= 10 * MS_CYCLES;
  endproperty
  a_line_len: assert property (p_line_len)
    else $error("line pulse length out of range");
  property p_vp_len;
    vp_off |-> hold_cnt + 1 >= 10 * MS_CYCLES
               && hold_cnt + 1 <= 20 * MS_CYCLES;
  endproperty
  a_vp_len: assert property (p_vp_len)
    else $error("bus pulse length out of range");
  property p_span;
    vp_off |-> span_cnt + 1 <= 100 * MS_CYCLES;
  endproperty
  a_span: assert property (p_span)
    else $error("both pulses took too long");
  property p_off_clean;
    ctl_wr && !reg_wdata[SRQ_BIT_EN] |-> reg_wdata[7:0] == 8'h00;
  endproperty
  a_off_clean: assert property (p_off_clean)
    else $error("disable left a control bit set");
endmodule
`default_nettype wire

// File: tb/tb.sv
// bench: firmware end against controller end, plus a
// register driver against a second controller end
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srq_pkg::*;
  localparam int MS = 10; // shortened millisecond tick
  // ====
  // clock, reset, bookkeeping
  logic ref_clk, nrst;
  int   error_cnt, num_checks, cyc;
  logic below, se0, sval, lp, vp, dc, sen, host_on;
  logic start, use_dc, busy, done, succ, f_init, f_to, attach;
  logic below2, se02, sval2, lp2, vp2, dc2, sen2;
  logic saw_lp, saw_dc, saw_off, bad_ord;
  srq_if link();
  srq_if regp();
  srq_device srq_device_inst (.ref_clk(ref_clk), .nrst(nrst),
    .bus(link.dev), .vbus_below_0v8(below), .line_se0(se0),
    .vbus_sess_valid(sval), .line_pulse_drv(lp),
    .vbus_pulse_drv(vp), .vbus_disch_drv(dc), .vbus_sense_en(sen));
  srq_firmware #(.MS_CYCLES(MS)) srq_firmware_inst (
    .ref_clk(ref_clk), .nrst(nrst), .bus(link.fw), .start(start),
    .use_discharge(use_dc), .busy(busy), .done(done),
    .success(succ), .fail_init(f_init), .fail_timeout(f_to),
    .soft_attach(attach));
  // second controller end, reached by the bench tasks
  srq_device srq_device_inst_b (.ref_clk(ref_clk), .nrst(nrst),
    .bus(regp.dev), .vbus_below_0v8(below2), .line_se0(se02),
    .vbus_sess_valid(sval2), .line_pulse_drv(lp2),
    .vbus_pulse_drv(vp2), .vbus_disch_drv(dc2),
    .vbus_sense_en(sen2));
  srq_properties #(.MS_CYCLES(MS)) srq_properties_inst (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
    .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata),
    .reg_rvalid(link.reg_rvalid));
  // ====
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // host answers a bus pulse; monitor drives; cut hangs short
  always @(posedge ref_clk) begin
    // a silent host lets the session level fall away
    if (host_on !== 1'b1) begin
      sval <= 1'b0;
    end else if (vp === 1'b1) begin
      sval <= 1'b1;
    end
    if (lp === 1'b1) saw_lp = 1'b1;
    if (vp === 1'b1 && (!saw_lp || lp !== 1'b0)) bad_ord = 1'b1;
    if (dc === 1'b1) saw_dc = 1'b1;
    if (sen === 1'b0) saw_off = 1'b1;
    cyc = cyc + 1;
    if (cyc == 70000) begin
      error_cnt++;
      $display("[ERR] run length expected under 70000 seen %0d", cyc);
      end_of_test();
    end
  end
  // ====
  // compare and access tasks
  task automatic chk1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    regp.reg_addr  = a;
    regp.reg_wdata = d;
    regp.reg_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    regp.reg_wr = 1'b0;
  endtask
  // answer stands right after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string n);
    @(posedge ref_clk);
    #1;
    regp.reg_addr = a;
    regp.reg_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    regp.reg_rd = 1'b0;
    chk1(n, 1'b1, regp.reg_rvalid);
    chk8(n, e, regp.reg_rdata);
  endtask
  // one firmware request, bounded wait for its done pulse
  task automatic run(input logic dsc, input int lim);
    int n;
    n = 0;
    saw_lp = 1'b0;
    saw_dc = 1'b0;
    saw_off = 1'b0;
    bad_ord = 1'b0;
    @(posedge ref_clk);
    #1;
    use_dc = dsc;
    start  = 1'b1;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    chk1("busy", 1'b1, busy);
    while (done !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk1("done", 1'b1, done);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ====
  // main sequence
  initial begin
    {nrst, start, use_dc, host_on, sval2} = 5'b0_0000;
    {below, se0, below2, se02} = 4'b1111;
    {regp.reg_addr, regp.reg_wdata} = 16'h0000;
    {regp.reg_wr, regp.reg_rd} = 2'b00;
    error_cnt  = 0;
    num_checks = 0;
    cyc        = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    // register flags and drives on the second end
    rd(SRQ_ADDR_CTRL, SRQ_CTRL_RESET, "ctrl reset");
    se02 = 1'b0;
    wr(SRQ_ADDR_CTRL, 8'h01);
    rd(SRQ_ADDR_CTRL, 8'h09, "violation set");
    chk1("sensing off", 1'b0, sen2);
    wr(SRQ_ADDR_CTRL, 8'h09);
    rd(SRQ_ADDR_CTRL, 8'h09, "violation kept");
    se02 = 1'b1;
    wr(SRQ_ADDR_CTRL, 8'h01);
    rd(SRQ_ADDR_CTRL, 8'h09, "zero leaves flag");
    wr(SRQ_ADDR_CTRL, 8'h09);
    rd(SRQ_ADDR_CTRL, 8'h01, "violation cleared");
    sval2 = 1'b1;
    wr(SRQ_ADDR_CTRL, 8'h11);
    rd(SRQ_ADDR_CTRL, 8'h11, "valid kept");
    sval2 = 1'b0;
    wr(SRQ_ADDR_CTRL, 8'h01);
    rd(SRQ_ADDR_CTRL, 8'h11, "zero leaves valid");
    wr(SRQ_ADDR_CTRL, 8'h11);
    rd(SRQ_ADDR_CTRL, 8'h01, "valid cleared");
    wr(SRQ_ADDR_CTRL, 8'h27);
    wr(8'h14, 8'h00);
    rd(8'h13, SRQ_RD_UNMAPPED, "unmapped read");
    rd(SRQ_ADDR_CTRL, 8'h27, "ctrl untouched");
    chk1("line drive", 1'b1, lp2);
    chk1("discharge drive", 1'b1, dc2);
    chk1("pulse drive", 1'b1, vp2);
    wr(SRQ_ADDR_CTRL, 8'h26);
    @(posedge ref_clk);
    #1;
    chk8("masked drives", 8'h01, {4'h0, lp2, vp2, dc2, sen2});
    $display("test registers done");
    // full request with discharge, host answers
    host_on = 1'b1;
    run(1'b1, 3000);
    chk1("success", 1'b1, succ);
    chk1("soft attach", 1'b1, attach);
    chk1("line pulse", 1'b1, saw_lp);
    chk1("pulse order", 1'b0, bad_ord);
    chk1("discharge", 1'b1, saw_dc);
    chk1("sensing off", 1'b1, saw_off);
    chk1("sensing back", 1'b1, sen);
    $display("test full_request done");
    // violated start conditions abort the request
    host_on = 1'b0;
    below = 1'b0;
    run(1'b0, 400);
    chk1("init fail", 1'b1, f_init);
    chk1("no line pulse", 1'b0, saw_lp);
    $display("test violation done");
    // reset between runs: the sticky valid flag of the first run would
    // otherwise answer the next poll, as firmware never clears it
    nrst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk1("attach in reset", 1'b0, attach);
    chk1("busy in reset", 1'b0, busy);
    nrst = 1'b1;
    // silent host: request times out
    below = 1'b1;
    run(1'b0, 60000);
    chk1("timeout", 1'b1, f_to);
    chk1("no success", 1'b0, succ);
    $display("test timeout done");
    end_of_test();
  end
endmodule
`default_nettype wire
